// file: tb/rat_host_model.sv
// Host model: drives 16-bit command frames on the serial port
`timescale 1ns/1ps
module rat_host_model (
    // Serial port
    output logic sck_o,
    output logic cs_b_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    initial begin
        sck_o = 1'b0;
        cs_b_o = 1'b1;
        sdi_o = 1'b0;
    end
    // Sends one word MSB first, 12 ns bit clock, sck still between frames
    task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
        rd = 16'h0000;
        cs_b_o = 1'b0;
        #7;
        for (int i = 15; i >= 0; i--) begin
            sdi_o = w[i];
            #6;
            rd = {rd[14:0], sdo_i};
            sck_o = 1'b1;
            #6;
            sck_o = 1'b0;
        end
        // Released line shows the inverse of the last bit
        sdi_o = ~sdi_o;
        #6;
        cs_b_o = 1'b1;
        // Gap covers decode and capture of the next FIFO head byte
        #450;
    endtask
endmodule // rat_host_model

// file: tb/tb_rat_cmd_unit.sv
// Testbench of the command unit
`timescale 1ns/1ps
module tb_rat_cmd_unit;
    import rat_pkg::*;
    typedef struct {logic [15:0] w; logic txd; logic sgn;} rat_row_t;
    logic clock_i, rst_b_i, sck, cs_b, sdi, sdo, pop, done, dq, vslow, vfast, txd;
    logic calc, prec, tgl, vflag, pol, sgn;
    logic [7:0] fifo_b;
    logic signed [7:0] err, ofs, fwo;
    logic [15:0] sync, rd_q;
    logic [3:0] code;
    logic [4:0] steps;
    logic [2:0] atten;
    logic t0;
    int err_total = 0;
    int cmp_count = 0;
    int pop_cnt = 0;
    int p0;
    rat_row_t rows [8] = '{'{16'h9800, 1'b0, 1'b0}, '{16'h9811, 1'b1, 1'b1},
        '{16'h9922, 1'b0, 1'b1}, '{16'h9933, 1'b1, 1'b0}, '{16'h98F4, 1'b0, 1'b0},
        '{16'h99F5, 1'b0, 1'b1}, '{16'h9876, 1'b1, 1'b1}, '{16'h9987, 1'b1, 1'b0}};

    rat_cmd_unit u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .sck_i(sck), .cs_b_i(cs_b),
        .sdi_i(sdi), .sdo_o(sdo), .rx_fifo_byte_i(fifo_b), .fifo_pop_o(pop),
        .afc_error_i(err), .afc_meas_done_i(done), .data_quality_flag_i(dq),
        .vdi_slow_i(vslow), .vdi_fast_mode_i(vfast), .tx_data_i(txd),
        .afc_offset_o(ofs), .freq_word_offset_o(fwo), .afc_calc_en_o(calc),
        .afc_precise_mode_o(prec), .afc_cycle_toggle_o(tgl), .valid_data_flag_o(vflag),
        .sync_pattern_o(sync), .deviation_polarity_o(pol), .deviation_code_o(code),
        .deviation_steps_o(steps), .deviation_sign_o(sgn), .power_atten_o(atten));
    rat_host_model u_host (.sck_o(sck), .cs_b_o(cs_b), .sdi_o(sdi), .sdo_i(sdo));

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (pop === 1'b1) pop_cnt <= pop_cnt + 1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] w);
        u_host.xfer(w, rd_q);
        cyc(2);
    endtask
    // Three done pulses: the last two see a full valid cycle and equal errors
    task automatic meas(input logic [7:0] e);
        repeat (3) begin
            @(posedge clock_i);
            err <= e;
            done <= 1'b1;
            @(posedge clock_i);
            done <= 1'b0;
            cyc(3);
        end
    endtask
    task automatic do_rst();
        @(posedge clock_i);
        rst_b_i <= 1'b0;
        cyc(16);
        rst_b_i <= 1'b1;
        cyc(2);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #300000;
        err_total++;
        wrap_up();
    end

    initial begin
        rst_b_i = 1'b0;
        fifo_b = 8'h00;
        err = 8'h00;
        done = 1'b0;
        dq = 1'b0;
        vslow = 1'b0;
        vfast = 1'b1;
        txd = 1'b0;
        do_rst();
        chk("sync_rst", 16'h2DD4, sync);
        chk("cfg_rst", 16'h0300, {6'h00, calc, prec, pol, code, atten});
        chk("ofs_rst", 16'h0000, {8'h00, ofs});
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].w);
            txd <= rows[i].txd;
            cyc(4);
            chk("tx_fields", {8'h00, rows[i].w[8:4], rows[i].w[2:0]},
                {8'h00, pol, code, atten});
            chk("dev_steps", {11'h000, 5'(rows[i].w[7:4]) + 5'h01}, {11'h000, steps});
            chk("dev_sign", {15'h0000, rows[i].sgn}, {15'h0000, sgn});
        end
        $display("test tx_rows done");
        wr(16'hCE5A);
        chk("sync_wr", 16'h2D5A, sync);
        wr(16'h0000);
        chk("status0", 16'h0000, rd_q);
        wr(16'hC15A);
        chk("sync_keep", 16'h2D5A, sync);
        $display("test sync done");
        foreach (rows[i]) if (i < 2) begin
            @(posedge clock_i);
            fifo_b <= (i == 0) ? 8'hA5 : 8'h3C;
            cyc(4);
            p0 = pop_cnt;
            wr(CMD_FIFO_RD);
            chk("fifo_rd", (i == 0) ? 16'h00A5 : 16'h003C, {8'h00, rd_q[7:0]});
            chk("fifo_pop", 16'h0001, 16'(pop_cnt - p0));
        end
        $display("test fifo done");
        dq <= 1'b1;
        cyc(4);
        chk("vdi_fast", 16'h0001, {15'h0000, vflag});
        t0 = tgl;
        meas(8'h05);
        chk("ofs_keep", 16'h0003, {8'h00, ofs});
        chk("fword", 16'h0003, {8'h00, fwo});
        chk("toggle", {15'h0000, ~t0}, {15'h0000, tgl});
        wr(16'h0000);
        chk("status_rd", {3'b000, ~t0, 12'h000}, rd_q);
        dq <= 1'b0;
        cyc(4);
        chk("vdi_low", 16'h0000, {15'h0000, vflag});
        chk("ofs_held", 16'h0003, {8'h00, ofs});
        $display("test afc_keep done");
        wr(16'hC4B7);
        dq <= 1'b1;
        meas(8'hFE);
        chk("ofs_drop", 16'h00FE, {8'h00, ofs});
        dq <= 1'b0;
        cyc(4);
        chk("ofs_clr", 16'h0000, {8'h00, ofs});
        wr(16'hC497);
        dq <= 1'b1;
        meas(8'h14);
        chk("clamp1", 16'h000F, {8'h00, ofs});
        wr(16'hC4A7);
        meas(8'hEC);
        chk("clamp2", 16'h00F8, {8'h00, ofs});
        $display("test afc_drop done");
        wr(16'hC407);
        meas(8'h14);
        chk("manual", 16'h00F8, {8'h00, ofs});
        wr(16'hC40F);
        chk("strobe", 16'h0014, {8'h00, ofs});
        wr(16'hC40D);
        chk("oe_off", 16'h0000, {8'h00, fwo});
        wr(16'hC408);
        chk("en_fi", 16'h0000, {14'h0000, calc, prec});
        t0 = tgl;
        meas(8'h01);
        chk("no_calc", {15'h0000, t0}, {15'h0000, tgl});
        $display("test afc_manual done");
        vfast <= 1'b0;
        vslow <= 1'b1;
        dq <= 1'b0;
        cyc(4);
        chk("vdi_slow", 16'h0001, {15'h0000, vflag});
        do_rst();
        wr(16'hC457);
        meas(8'h01);
        chk("once", 16'h0001, {8'h00, ofs});
        meas(8'h09);
        chk("once_hold", 16'h0001, {8'h00, ofs});
        $display("test afc_once done");
        wrap_up();
    end
endmodule // tb_rat_cmd_unit

// file: verilog/rat_cmd_unit.sv
// Command unit: serial command port, sync byte, FIFO read, AFC control, TX config
`timescale 1ns/1ps
module rat_cmd_unit #(
    parameter int ERR_W = 8
) (
    // Core clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Serial command port
    input wire logic sck_i,
    input wire logic cs_b_i,
    input wire logic sdi_i,
    output logic sdo_o,
    // Receive FIFO
    input wire logic [7:0] rx_fifo_byte_i,
    output logic fifo_pop_o,
    // Frequency measurement and TX data
    input wire logic signed [ERR_W-1:0] afc_error_i,
    input wire logic afc_meas_done_i,
    input wire logic data_quality_flag_i,
    input wire logic vdi_slow_i,
    input wire logic vdi_fast_mode_i,
    input wire logic tx_data_i,
    // AFC outputs
    output logic signed [ERR_W-1:0] afc_offset_o,
    output logic signed [ERR_W-1:0] freq_word_offset_o,
    output logic afc_calc_en_o,
    output logic afc_precise_mode_o,
    output logic afc_cycle_toggle_o,
    output logic valid_data_flag_o,
    // Sync pattern and TX configuration
    output logic [15:0] sync_pattern_o,
    output logic deviation_polarity_o,
    output logic [3:0] deviation_code_o,
    output logic [4:0] deviation_steps_o,
    output logic deviation_sign_o,
    output logic [2:0] power_atten_o
);
    import rat_pkg::*;

    // ------------------------------------------------------------------
    // Link domain: shift in, shift out
    // ------------------------------------------------------------------
    logic link_rst_b;
    logic [3:0] cnt_r, cnt_nxt;
    logic [14:0] sh_r, sh_nxt;
    logic [7:0] out_r, out_nxt;
    logic [15:0] word_r, word_nxt;
    logic tog_r, tog_nxt;
    logic afc_cycle_toggle_l1_r, afc_cycle_toggle_l2_r;
    logic [7:0] snap_r, snap_nxt;
    logic [7:0] hi_byte;

    // Chip select high ends the frame without needing a clock edge
    assign link_rst_b = rst_b_i & ~cs_b_i;
    assign hi_byte = {sh_r[6:0], sdi_i};

    always_comb begin
        cnt_nxt = cnt_r + 4'h1;
        sh_nxt = {sh_r[13:0], sdi_i};
        out_nxt = {out_r[6:0], 1'b0};
        // Status bit waits two edges so the toggle has crossed into this domain
        if (cnt_r == 4'h2 && !sh_r[1]) begin
            out_nxt = {afc_cycle_toggle_l2_r, 7'h00};
        end else if (cnt_r == BIT_HI_DONE && hi_byte == CMD_FIFO_HI) begin
            out_nxt = snap_r;
        end
    end

    always_ff @(posedge sck_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            cnt_r <= 4'h0;
            sh_r <= 15'h0000;
            out_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            out_r <= out_nxt;
        end
    end

    always_comb begin
        word_nxt = word_r;
        tog_nxt = tog_r;
        if (cnt_r == BIT_LAST) begin
            word_nxt = {sh_r, sdi_i};
            tog_nxt = ~tog_r;
        end
    end

    always_ff @(posedge sck_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            word_r <= 16'h0000;
            tog_r <= 1'b0;
            afc_cycle_toggle_l1_r <= 1'b0;
            afc_cycle_toggle_l2_r <= 1'b0;
        end else begin
            word_r <= word_nxt;
            tog_r <= tog_nxt;
            afc_cycle_toggle_l1_r <= afc_cycle_toggle_o;
            afc_cycle_toggle_l2_r <= afc_cycle_toggle_l1_r;
        end
    end

    assign sdo_o = out_r[7];

    // ------------------------------------------------------------------
    // Core domain: synchronisers
    // ------------------------------------------------------------------
    logic tg1_r, tg2_r, tg3_r, cs1_r, cs2_r;
    logic dq1_r, dq2_r, vs1_r, vs2_r, td1_r, td2_r;
    logic word_stb;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tg1_r <= 1'b0;
            tg2_r <= 1'b0;
            tg3_r <= 1'b0;
            cs1_r <= 1'b1;
            cs2_r <= 1'b1;
            dq1_r <= 1'b0;
            dq2_r <= 1'b0;
            vs1_r <= 1'b0;
            vs2_r <= 1'b0;
            td1_r <= 1'b0;
            td2_r <= 1'b0;
        end else begin
            tg1_r <= tog_r;
            tg2_r <= tg1_r;
            tg3_r <= tg2_r;
            cs1_r <= cs_b_i;
            cs2_r <= cs1_r;
            dq1_r <= data_quality_flag_i;
            dq2_r <= dq1_r;
            vs1_r <= vdi_slow_i;
            vs2_r <= vs1_r;
            td1_r <= tx_data_i;
            td2_r <= td1_r;
        end
    end

    // Word is stable in the link domain once its toggle has crossed
    assign word_stb = tg2_r ^ tg3_r;
    assign valid_data_flag_o = vdi_fast_mode_i ? dq2_r : vs2_r;

    // ------------------------------------------------------------------
    // Command registers and AFC state
    // ------------------------------------------------------------------
    function automatic logic signed [ERR_W-1:0] clamp(
        input logic signed [ERR_W-1:0] v,
        input logic [1:0] rng
    );
        logic signed [ERR_W-1:0] hi;
        logic signed [ERR_W-1:0] lo;
        hi = ERR_W'(15);
        lo = -ERR_W'(16);
        case (rng)
            2'h1: begin
                hi = ERR_W'(15);
                lo = -ERR_W'(16);
            end
            2'h2: begin
                hi = ERR_W'(7);
                lo = -ERR_W'(8);
            end
            2'h3: begin
                hi = ERR_W'(3);
                lo = -ERR_W'(4);
            end
            default: begin
                hi = ERR_W'(15);
                lo = -ERR_W'(16);
            end
        endcase
        if (rng == 2'h0) begin
            clamp = v;
        end else if (v > hi) begin
            clamp = hi;
        end else if (v < lo) begin
            clamp = lo;
        end else begin
            clamp = v;
        end
    endfunction

    logic [7:0] sync_lo_r, sync_lo_nxt;
    logic [15:0] afc_r, afc_nxt;
    logic [8:0] tx_r, tx_nxt;
    logic signed [ERR_W-1:0] ofs_r, ofs_nxt, last_r, last_nxt;
    logic last_ok_r, last_ok_nxt;
    logic vwin_r, vwin_nxt;
    logic once_r, once_nxt;
    logic afc_cycle_toggle_r, afc_cycle_toggle_nxt;
    logic vd_prev_r;
    logic pop_r, pop_nxt;
    rat_auto_t mode;
    logic calc_en;

    assign mode = rat_auto_t'(afc_r[AFC_AUTO_HI:AFC_AUTO_LO]);
    assign calc_en = afc_r[AFC_CALC_EN];

    always_comb begin
        sync_lo_nxt = sync_lo_r;
        afc_nxt = afc_r;
        tx_nxt = tx_r;
        ofs_nxt = ofs_r;
        last_nxt = last_r;
        last_ok_nxt = last_ok_r;
        vwin_nxt = vwin_r & valid_data_flag_o;
        once_nxt = once_r;
        afc_cycle_toggle_nxt = afc_cycle_toggle_r;
        pop_nxt = 1'b0;
        snap_nxt = cs2_r ? rx_fifo_byte_i : snap_r;
        if (word_stb && word_r[15]) begin
            if (word_r[15:8] == CMD_SYNC_HI) begin
                sync_lo_nxt = word_r[7:0];
            end
            if (word_r == CMD_FIFO_RD) begin
                pop_nxt = 1'b1;
            end
            if (word_r[15:8] == CMD_AFC_HI) begin
                afc_nxt = word_r;
                if (word_r[AFC_STROBE] && !afc_r[AFC_STROBE]) begin
                    ofs_nxt = clamp(last_r, word_r[AFC_RANGE_HI:AFC_RANGE_LO]);
                end
            end
            if (word_r[15:9] == CMD_TX_HI) begin
                tx_nxt = word_r[8:0];
            end
        end
        if (calc_en && afc_meas_done_i) begin
            afc_cycle_toggle_nxt = ~afc_cycle_toggle_r;
            last_nxt = afc_error_i;
            last_ok_nxt = vwin_r & valid_data_flag_o;
            vwin_nxt = 1'b1;
            if (mode != RAT_AUTO_OFF && vwin_r && valid_data_flag_o && last_ok_r
                && afc_error_i == last_r
                && !(mode == RAT_AUTO_ONCE && once_r)) begin
                ofs_nxt = clamp(afc_error_i, afc_r[AFC_RANGE_HI:AFC_RANGE_LO]);
                once_nxt = 1'b1;
            end
        end
        if (mode == RAT_AUTO_DROP && vd_prev_r && !valid_data_flag_o) begin
            ofs_nxt = '0;
        end
    end

    // Keep mode leaves the offset alone on valid-data changes
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_lo_r <= SYNC_RST[7:0];
            afc_r <= AFC_RST;
            tx_r <= TX_RST[8:0];
            ofs_r <= '0;
            last_r <= '0;
            last_ok_r <= 1'b0;
            vwin_r <= 1'b0;
            once_r <= 1'b0;
            afc_cycle_toggle_r <= 1'b0;
            vd_prev_r <= 1'b0;
            pop_r <= 1'b0;
            snap_r <= 8'h00;
        end else begin
            sync_lo_r <= sync_lo_nxt;
            afc_r <= afc_nxt;
            tx_r <= tx_nxt;
            ofs_r <= ofs_nxt;
            last_r <= last_nxt;
            last_ok_r <= last_ok_nxt;
            vwin_r <= vwin_nxt;
            once_r <= once_nxt;
            afc_cycle_toggle_r <= afc_cycle_toggle_nxt;
            vd_prev_r <= valid_data_flag_o;
            pop_r <= pop_nxt;
            snap_r <= snap_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign fifo_pop_o = pop_r;
    assign afc_offset_o = ofs_r;
    assign freq_word_offset_o = afc_r[AFC_OFS_EN] ? ofs_r : '0;
    assign afc_calc_en_o = calc_en;
    assign afc_precise_mode_o = afc_r[AFC_FINE];
    assign afc_cycle_toggle_o = afc_cycle_toggle_r;
    assign sync_pattern_o = {SYNC_HI_BYTE, sync_lo_r};
    assign deviation_polarity_o = tx_r[TX_POL];
    assign deviation_code_o = tx_r[TX_DEV_HI:TX_DEV_LO];
    assign deviation_steps_o = {1'b0, tx_r[TX_DEV_HI:TX_DEV_LO]} + 5'h01;
    assign deviation_sign_o = tx_r[TX_POL] ^ td2_r;
    assign power_atten_o = tx_r[TX_PWR_HI:TX_PWR_LO];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    sync_write_a: assert property (word_stb && word_r[15:8] == CMD_SYNC_HI
        |=> sync_pattern_o[7:0] == $past(word_r[7:0])) else $error("sync byte");
    sync_high_a: assert property (sync_pattern_o[15:8] == 8'h2D)
        else $error("sync high byte");
    fifo_pop_a: assert property (word_stb && word_r == CMD_FIFO_RD
        |=> fifo_pop_o ##1 !fifo_pop_o) else $error("fifo pop");
    ofs_gate_a: assert property (!afc_r[AFC_OFS_EN] |-> freq_word_offset_o == '0)
        else $error("offset gate");
    range_lim_a: assert property (afc_r[5:4] == 2'h3
        && $changed(ofs_r) && !$changed(afc_r) |-> ofs_r <= 3 && ofs_r >= -4)
        else $error("range");
    drop_clear_a: assert property (mode == RAT_AUTO_DROP && $fell(valid_data_flag_o)
        |=> ofs_r == '0) else $error("drop");
    keep_hold_a: assert property (mode == RAT_AUTO_KEEP && $fell(valid_data_flag_o)
        && !word_stb && !afc_meas_done_i |=> $stable(ofs_r)) else $error("keep");
    toggle_done_a: assert property (calc_en && afc_meas_done_i
        |=> $changed(afc_cycle_toggle_o)) else $error("toggle");
    calc_off_a: assert property (!calc_en && !word_stb
        |=> $stable(afc_cycle_toggle_o)) else $error("calc off");
    sign_xor_a: assert property ($past(rst_b_i, 2)
        |-> deviation_sign_o == (deviation_polarity_o ^ $past(tx_data_i, 2)))
        else $error("sign");
    manual_hold_a: assert property (mode == RAT_AUTO_OFF && !word_stb
        |=> $stable(ofs_r)) else $error("manual");
    fast_vdi_a: assert property ($past(rst_b_i, 2) && vdi_fast_mode_i
        |-> valid_data_flag_o == $past(data_quality_flag_i, 2)) else $error("fast vdi");
    once_hold_a: assert property (mode == RAT_AUTO_ONCE && once_r && !word_stb
        |=> $stable(ofs_r)) else $error("once");

    strobe_c: cover property (word_stb && word_r[15:8] == CMD_AFC_HI && word_r[AFC_STROBE]);
    auto_upd_c: cover property (mode == RAT_AUTO_KEEP ##1 $changed(ofs_r));
    fifo_rd_c: cover property (fifo_pop_o);
    tx_cfg_c: cover property (word_stb && word_r[15:9] == CMD_TX_HI);
endmodule // rat_cmd_unit

// file: verilog/rat_pkg.sv
// Package: command codes, field positions and reset values of the command unit
package rat_pkg;
    // ------------------------------------------------------------------
    // Command words
    // ------------------------------------------------------------------
    localparam int CMD_W = 16;
    localparam logic [7:0] CMD_SYNC_HI = 8'hCE;
    localparam logic [7:0] CMD_FIFO_HI = 8'hB0;
    localparam logic [7:0] CMD_AFC_HI = 8'hC4;
    localparam logic [6:0] CMD_TX_HI = 7'h4C;
    localparam logic [15:0] CMD_FIFO_RD = 16'hB000;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] SYNC_RST = 16'hCED4;
    localparam logic [15:0] AFC_RST = 16'hC4F7;
    localparam logic [15:0] TX_RST = 16'h9800;
    localparam logic [7:0] SYNC_HI_BYTE = 8'h2D;
    // ------------------------------------------------------------------
    // Frequency-control fields
    // ------------------------------------------------------------------
    localparam int AFC_AUTO_HI = 7;
    localparam int AFC_AUTO_LO = 6;
    localparam int AFC_RANGE_HI = 5;
    localparam int AFC_RANGE_LO = 4;
    localparam int AFC_STROBE = 3;
    localparam int AFC_FINE = 2;
    localparam int AFC_OFS_EN = 1;
    localparam int AFC_CALC_EN = 0;
    // ------------------------------------------------------------------
    // Transmit configuration fields
    // ------------------------------------------------------------------
    localparam int TX_POL = 8;
    localparam int TX_DEV_HI = 7;
    localparam int TX_DEV_LO = 4;
    localparam int TX_PWR_HI = 2;
    localparam int TX_PWR_LO = 0;
    localparam int DEV_STEP_KHZ = 15;
    // ------------------------------------------------------------------
    // Serial frame
    // ------------------------------------------------------------------
    localparam logic [3:0] BIT_HI_DONE = 4'h7;
    localparam logic [3:0] BIT_LAST = 4'hF;

    typedef enum logic [1:0] {
        RAT_AUTO_OFF = 2'h0,
        RAT_AUTO_ONCE = 2'h1,
        RAT_AUTO_DROP = 2'h2,
        RAT_AUTO_KEEP = 2'h3
    } rat_auto_t;
endpackage
